// ==== hw/exec_pkg.sv ====
// Constants, types and state carrier for the add, and and branch execution unit
package exec_pkg;

  // Widths
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PC_W   = 21;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned BUS_AW = 13;

  // Values after reset
  localparam logic [PC_W-1:0]   PC_RST     = 21'h000000;
  localparam logic [7:0]        WREG_RST   = 8'h00;
  localparam logic [4:0]        STATUS_RST = 5'h00;
  localparam logic [BANK_W-1:0] BANK_RST   = 4'h0;
  localparam logic              EXT_RST    = 1'b0;

  // Program counter moves one 16-bit word per fetch
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  // Status field positions
  localparam int unsigned ST_C  = 0;
  localparam int unsigned ST_DC = 1;
  localparam int unsigned ST_Z  = 2;
  localparam int unsigned ST_OV = 3;
  localparam int unsigned ST_N  = 4;

  // Quick-access bank split and the indexed window limit (95)
  localparam logic [7:0]        ACCESS_SPLIT = 8'h60;
  localparam logic [7:0]        IDX_LIMIT    = 8'h5F;
  localparam logic [BANK_W-1:0] ACCESS_LO    = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI    = 4'hF;

  // Opcode patterns
  localparam logic [5:0] OPC_ADDC = 6'h08;
  localparam logic [5:0] OPC_ANDF = 6'h05;
  localparam logic [7:0] OPC_ANDL = 8'h0B;
  localparam logic [7:0] OPC_BC   = 8'hE2;
  localparam logic [7:0] OPC_BNC  = 8'hE3;
  localparam logic [7:0] OPC_BN   = 8'hE6;
  localparam logic [3:0] OPC_BCLR = 4'h9;

  // Instruction word field positions
  localparam int unsigned IR_DEST = 9;
  localparam int unsigned IR_BANK = 8;
  localparam int unsigned IR_BIT  = 9;

  // Register bus map
  localparam logic [BUS_AW-1:0] REG_WREG   = 13'h0000;
  localparam logic [BUS_AW-1:0] REG_STATUS = 13'h0001;
  localparam logic [BUS_AW-1:0] REG_BANK   = 13'h0002;
  localparam logic [BUS_AW-1:0] REG_CTRL   = 13'h0003;
  localparam int unsigned       MEM_WIN    = 12;
  localparam int unsigned       CTRL_EXT   = 0;
  localparam int unsigned       CTRL_BUSY  = 1;

  typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROC, PH_WRITE} phase_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_ADDC, OP_ANDL, OP_ANDF, OP_BCLR, OP_BC, OP_BNC, OP_BN
  } op_t;

  typedef struct packed {
    logic [BUS_AW-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

  typedef struct packed {
    logic              we;
    logic              re;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } mem_port_t;

  typedef struct packed {
    phase_t            ph;
    logic              dead;
    op_t               op;
    logic [15:0]       ir;
    logic [ADDR_W-1:0] fadr;
    logic [7:0]        res;
    logic [4:0]        sflag;
    logic [4:0]        smask;
    logic              take;
    logic [7:0]        wreg;
    logic [4:0]        status;
    logic [BANK_W-1:0] bank;
    logic              ext;
    logic [PC_W-1:0]   pc;
    logic [7:0]        rdata;
    logic              rd_mem;
  } exec_state_t;

endpackage

// ==== hw/data_ram.sv ====
// Two-port data memory with registered read data
`timescale 1ns/10ps
module data_ram
  import exec_pkg::*;
(
  // Clock
  input  wire logic      mclk,
  input  wire logic      ce,
  // Execution port, wins a same-address write collision
  input  wire mem_port_t port_a,
  output logic [7:0]     rdata_a,
  // Bus port
  input  wire mem_port_t port_b,
  output logic [7:0]     rdata_b
);

  logic [7:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge mclk) begin
    if (ce) begin
      if (port_b.we && !(port_a.we && port_a.addr == port_b.addr)) begin
        mem[port_b.addr] <= port_b.wdata;
      end
      if (port_a.we) begin
        mem[port_a.addr] <= port_a.wdata;
      end
      if (port_a.re) begin
        rdata_a <= mem[port_a.addr];
      end
      if (port_b.re) begin
        rdata_b <= mem[port_b.addr];
      end
    end
  end

endmodule

// ==== hw/instr_exec.sv ====
// Four-phase decode and execute unit for add, and, bit clear and branch
`timescale 1ns/10ps
module instr_exec
  import exec_pkg::*;
(
  // Clock, reset, clock enable
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              ce,
  // Instruction from fetch
  input  wire logic [15:0]       instr_word,
  input  wire logic              instr_valid,
  output logic                   instr_ready,
  // Base of the indexed literal offset window
  input  wire logic [ADDR_W-1:0] index_base,
  // Register bus
  input  wire bus_req_t          bus_req,
  output logic [7:0]             bus_rdata,
  // Core state
  output logic [PC_W-1:0]        pc_out,
  output logic [7:0]             wreg_out,
  output logic [4:0]             status_out
);

  exec_state_t st_ff;
  exec_state_t nxt_st;
  mem_port_t   exec_port;
  mem_port_t   bus_port;
  logic [7:0]  exec_rdata;
  logic [7:0]  bus_mem_rdata;

  // Pure decode of the opcode field
  function automatic op_t decode(input logic [15:0] w);
    if (w[15:10] == OPC_ADDC) begin
      return OP_ADDC;
    end else if (w[15:10] == OPC_ANDF) begin
      return OP_ANDF;
    end else if (w[15:8] == OPC_ANDL) begin
      return OP_ANDL;
    end else if (w[15:12] == OPC_BCLR) begin
      return OP_BCLR;
    end else if (w[15:8] == OPC_BC) begin
      return OP_BC;
    end else if (w[15:8] == OPC_BNC) begin
      return OP_BNC;
    end else if (w[15:8] == OPC_BN) begin
      return OP_BN;
    end else begin
      return OP_NONE;
    end
  endfunction

  // Data address from the 8-bit file field
  function automatic logic [ADDR_W-1:0] file_addr(
    input logic [7:0]        f,
    input logic              a,
    input logic [BANK_W-1:0] bank,
    input logic              ext,
    input logic [ADDR_W-1:0] idx
  );
    if (a) begin
      return {bank, f};
    end else if (ext && f <= IDX_LIMIT) begin
      // The window wraps within the 12-bit data space
      return idx + ADDR_W'(f);
    end else if (f < ACCESS_SPLIT) begin
      return {ACCESS_LO, f};
    end else begin
      return {ACCESS_HI, f};
    end
  endfunction

  // Negative and zero flags placed in a status-shaped vector
  function automatic logic [4:0] nz_flags(input logic [7:0] r);
    logic [4:0] v;
    v       = '0;
    v[ST_N] = r[7];
    v[ST_Z] = (r == 8'h00);
    return v;
  endfunction

  function automatic logic [4:0] nz_mask();
    logic [4:0] m;
    m       = '0;
    m[ST_N] = 1'b1;
    m[ST_Z] = 1'b1;
    return m;
  endfunction

  function automatic logic uses_file(input op_t op);
    return (op == OP_ADDC) || (op == OP_ANDF) || (op == OP_BCLR);
  endfunction

  // Flags outside the mask keep their old value
  function automatic logic [4:0] merge_flags(
    input logic [4:0] old,
    input logic [4:0] flg,
    input logic [4:0] msk
  );
    return (old & ~msk) | (flg & msk);
  endfunction

  // Condition test of the three relative branches
  function automatic logic branch_cond(input op_t op, input logic [4:0] s);
    case (op)
      OP_BC:   return s[ST_C];
      OP_BNC:  return !s[ST_C];
      OP_BN:   return s[ST_N];
      default: return 1'b0;
    endcase
  endfunction

  // All five flags of an 8-bit add with carry in
  function automatic logic [4:0] add_flags(
    input logic [7:0] w,
    input logic [7:0] f,
    input logic       c
  );
    logic [8:0] s;
    logic [4:0] h;
    logic [4:0] v;
    s        = {1'b0, w} + {1'b0, f} + 9'(c);
    h        = {1'b0, w[3:0]} + {1'b0, f[3:0]} + 5'(c);
    v        = nz_flags(s[7:0]);
    v[ST_C]  = s[8];
    v[ST_DC] = h[4];
    // Signed overflow: like-signed operands giving a result of the other sign
    v[ST_OV] = (w[7] == f[7]) && (s[7] != w[7]);
    return v;
  endfunction

  // Execution-side write of one data byte
  function automatic mem_port_t file_write(
    input logic [ADDR_W-1:0] a,
    input logic [7:0]        d
  );
    mem_port_t p;
    p       = '0;
    p.we    = 1'b1;
    p.addr  = a;
    p.wdata = d;
    return p;
  endfunction

  always_comb begin
    logic [7:0]      wv;
    logic [7:0]      fv;
    logic [7:0]      lit;
    logic [PC_W-1:0] offs;
    wv          = st_ff.wreg;
    fv          = exec_rdata;
    lit         = st_ff.ir[7:0];
    // Offset counts words, so it is doubled into bytes
    offs        = {{(PC_W-9){lit[7]}}, lit, 1'b0};
    nxt_st      = st_ff;
    exec_port   = '0;
    bus_port    = '0;
    // Combinational so a waiting word is taken in the cycle the slot frees
    instr_ready = ce && (st_ff.ph == PH_DECODE) && !st_ff.dead;

    if (ce) begin
      // Bus access comes first so a same-cycle execution write overrides it
      nxt_st.rdata  = 8'h00;
      nxt_st.rd_mem = 1'b0;
      if (bus_req.addr[MEM_WIN]) begin
        bus_port.addr  = bus_req.addr[ADDR_W-1:0];
        bus_port.wdata = bus_req.wdata;
        bus_port.we    = bus_req.wr;
        bus_port.re    = bus_req.rd;
        nxt_st.rd_mem  = bus_req.rd;
      end else begin
        if (bus_req.wr) begin
          case (bus_req.addr)
            REG_WREG:   nxt_st.wreg   = bus_req.wdata;
            REG_STATUS: nxt_st.status = bus_req.wdata[4:0];
            REG_BANK:   nxt_st.bank   = bus_req.wdata[BANK_W-1:0];
            REG_CTRL:   nxt_st.ext    = bus_req.wdata[CTRL_EXT];
            default:    nxt_st.ext    = st_ff.ext;
          endcase
        end
        if (bus_req.rd) begin
          case (bus_req.addr)
            REG_WREG:   nxt_st.rdata = st_ff.wreg;
            REG_STATUS: nxt_st.rdata = {3'h0, st_ff.status};
            REG_BANK:   nxt_st.rdata = {{(8-BANK_W){1'b0}}, st_ff.bank};
            REG_CTRL: begin
              nxt_st.rdata[CTRL_EXT]  = st_ff.ext;
              nxt_st.rdata[CTRL_BUSY] = (st_ff.ph != PH_DECODE) || st_ff.dead;
            end
            default:    nxt_st.rdata = 8'h00;
          endcase
        end
      end

      case (st_ff.ph)
        // Q1: take and decode the word, step the counter past it
        PH_DECODE: begin
          if (st_ff.dead) begin
            nxt_st.ph = PH_READ;
          end else if (instr_valid) begin
            nxt_st.ir   = instr_word;
            nxt_st.op   = decode(instr_word);
            nxt_st.fadr = file_addr(instr_word[7:0], instr_word[IR_BANK],
                                    st_ff.bank, st_ff.ext, index_base);
            nxt_st.pc   = st_ff.pc + PC_STEP;
            nxt_st.take = 1'b0;
            nxt_st.ph   = PH_READ;
          end
        end

        // Q2: fetch the file operand; literals need no access
        PH_READ: begin
          if (!st_ff.dead && uses_file(st_ff.op)) begin
            exec_port.re   = 1'b1;
            exec_port.addr = st_ff.fadr;
          end
          nxt_st.ph = PH_PROC;
        end

        // Q3: compute result, flags and branch decision
        PH_PROC: begin
          nxt_st.smask = '0;
          nxt_st.sflag = '0;
          nxt_st.take  = 1'b0;
          if (!st_ff.dead) begin
            case (st_ff.op)
              OP_ADDC: begin
                nxt_st.res   = wv + fv + 8'(st_ff.status[ST_C]);
                nxt_st.sflag = add_flags(wv, fv, st_ff.status[ST_C]);
                nxt_st.smask = 5'h1F;
              end
              OP_ANDL: begin
                nxt_st.res   = wv & lit;
                nxt_st.sflag = nz_flags(wv & lit);
                nxt_st.smask = nz_mask();
              end
              OP_ANDF: begin
                nxt_st.res   = wv & fv;
                nxt_st.sflag = nz_flags(wv & fv);
                nxt_st.smask = nz_mask();
              end
              OP_BCLR: begin
                nxt_st.res = fv & ~(8'h01 << st_ff.ir[IR_BIT +: 3]);
              end
              // Flags are read here, after any write-back of the previous instruction
              default: nxt_st.take = branch_cond(st_ff.op, st_ff.status);
            endcase
          end
          nxt_st.ph = PH_WRITE;
        end

        // Q4: write the destination; a taken branch then idles for four cycles
        PH_WRITE: begin
          if (st_ff.dead) begin
            nxt_st.dead = 1'b0;
          end else begin
            case (st_ff.op)
              OP_ADDC, OP_ANDF: begin
                if (st_ff.ir[IR_DEST]) begin
                  exec_port = file_write(st_ff.fadr, st_ff.res);
                end else begin
                  nxt_st.wreg = st_ff.res;
                end
                nxt_st.status = merge_flags(st_ff.status, st_ff.sflag, st_ff.smask);
              end
              OP_ANDL: begin
                nxt_st.wreg   = st_ff.res;
                nxt_st.status = merge_flags(st_ff.status, st_ff.sflag, st_ff.smask);
              end
              OP_BCLR: begin
                exec_port = file_write(st_ff.fadr, st_ff.res);
              end
              OP_BC, OP_BNC, OP_BN: begin
                if (st_ff.take) begin
                  nxt_st.pc   = st_ff.pc + offs;
                  nxt_st.dead = 1'b1;
                end
              end
              default: nxt_st.dead = 1'b0;
            endcase
          end
          nxt_st.ph = PH_DECODE;
        end

        default: nxt_st.ph = PH_DECODE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      // Data memory is not cleared; only the core state starts known
      st_ff.ph     <= PH_DECODE;
      st_ff.dead   <= 1'b0;
      st_ff.op     <= OP_NONE;
      st_ff.ir     <= 16'h0000;
      st_ff.fadr   <= '0;
      st_ff.res    <= 8'h00;
      st_ff.sflag  <= 5'h00;
      st_ff.smask  <= 5'h00;
      st_ff.take   <= 1'b0;
      st_ff.wreg   <= WREG_RST;
      st_ff.status <= STATUS_RST;
      st_ff.bank   <= BANK_RST;
      st_ff.ext    <= EXT_RST;
      st_ff.pc     <= PC_RST;
      st_ff.rdata  <= 8'h00;
      st_ff.rd_mem <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Memory read data is registered inside the memory, so both stand one cycle on
  data_ram u_ram (
    .mclk    (mclk),
    .ce      (ce),
    .port_a  (exec_port),
    .rdata_a (exec_rdata),
    .port_b  (bus_port),
    .rdata_b (bus_mem_rdata)
  );

  // Both sources are flops; the mux only picks which one answers
  assign bus_rdata  = st_ff.rd_mem ? bus_mem_rdata : st_ff.rdata;
  assign pc_out     = st_ff.pc;
  assign wreg_out   = st_ff.wreg;
  assign status_out = st_ff.status;

endmodule

// ==== verification/exec_asserts.sv ====
// Port-level checks of the execution unit
`timescale 1ns/10ps
module exec_asserts
  import exec_pkg::*;
(
  // Clock and control
  input wire logic            mclk,
  input wire logic            reset,
  input wire logic            ce,
  // Instruction port
  input wire logic [15:0]     instr_word,
  input wire logic            instr_valid,
  input wire logic            instr_ready,
  // Core state
  input wire logic [PC_W-1:0] pc_out,
  input wire logic [7:0]      wreg_out,
  input wire logic [4:0]      status_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic            take, is_br, br_go, to_w, to_f;
  logic [7:0]      op, and_lit;
  logic [2:0]      cdo;
  logic [PC_W-1:0] tgt;
  always_comb begin
    take = ce && instr_valid && instr_ready;
    op = instr_word[15:8];
    is_br = op == OPC_BC || op == OPC_BNC || op == OPC_BN;
    br_go = (op == OPC_BC && status_out[ST_C]) || (op == OPC_BNC && !status_out[ST_C])
      || (op == OPC_BN && status_out[ST_N]);
    tgt = pc_out + PC_STEP + {{(PC_W-9){instr_word[7]}}, instr_word[7:0], 1'b0};
    and_lit = wreg_out & instr_word[7:0];
    cdo = {status_out[ST_OV], status_out[ST_DC], status_out[ST_C]};
    to_f = instr_word[15:10] inside {OPC_ADDC, OPC_ANDF};
    to_w = op == OPC_ANDL || (to_f && !instr_word[IR_DEST]);
    to_f = to_f && instr_word[IR_DEST];
  end
  property p_busy; take |=> !instr_ready [*3]; endproperty
  a_busy: assert property (p_busy) else $error("ready during busy phases");
  property p_step; take |=> pc_out == $past(pc_out) + PC_STEP; endproperty
  a_step: assert property (p_step) else $error("pc not stepped at take");
  property p_tgt; take && br_go |-> ##4 pc_out == $past(tgt, 4); endproperty
  a_tgt: assert property (p_tgt) else $error("branch target wrong");
  property p_dead; take && br_go |=> !instr_ready [*7]; endproperty
  a_dead: assert property (p_dead) else $error("no dead cycle after branch");
  property p_skip; take && is_br && !br_go |-> ##2 $stable(pc_out) [*3]; endproperty
  a_skip: assert property (p_skip) else $error("untaken branch moved pc");
  property p_andl;
    take && op == OPC_ANDL |-> ##4 wreg_out == $past(and_lit, 4) && cdo == $past(cdo, 4);
  endproperty
  a_andl: assert property (p_andl) else $error("literal and wrong");
  property p_nz;
    take && to_w |-> ##4 status_out[ST_N] == wreg_out[7] && status_out[ST_Z] == (wreg_out == 8'h00);
  endproperty
  a_nz: assert property (p_nz) else $error("N or Z wrong");
  property p_keep; take && to_f |-> ##4 wreg_out == $past(wreg_out, 4); endproperty
  a_keep: assert property (p_keep) else $error("file result reached W");
  property p_bclr;
    take && instr_word[15:12] == OPC_BCLR |-> ##4 status_out == $past(status_out, 4);
  endproperty
  a_bclr: assert property (p_bclr) else $error("bit clear changed flags");
  c_go: cover property (take && br_go);
  c_skip: cover property (take && is_br && !br_go);
  c_andl: cover property (take && op == OPC_ANDL);
endmodule

bind instr_exec exec_asserts exec_asserts_inst (
  .mclk(mclk), .reset(reset), .ce(ce), .instr_word(instr_word), .instr_valid(instr_valid),
  .instr_ready(instr_ready), .pc_out(pc_out), .wreg_out(wreg_out), .status_out(status_out)
);

// ==== verification/fetch_model.sv ====
// Fetch side model: offers one word and holds it until taken
`timescale 1ns/10ps
module fetch_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Bench request
  input  wire logic        send,
  input  wire logic [15:0] word,
  // Instruction port
  input  wire logic        instr_ready,
  output logic [15:0]      instr_word = 16'h0000,
  output logic             instr_valid = 1'b0
);
  always @(posedge mclk) begin
    if (reset) begin
      instr_valid <= 1'b0;
    end else if (send) begin
      instr_valid <= 1'b1;
      instr_word  <= word;
    end else if (instr_valid && instr_ready) begin
      instr_valid <= 1'b0;
      // A released word must not look like the last one
      instr_word  <= ~instr_word;
    end
  end
endmodule

// ==== verification/tb_instr_exec.sv ====
// Directed bench for the execution unit
`timescale 1ns/10ps
module tb_instr_exec
  import exec_pkg::*;
;
  logic            mclk = 1'b0;
  logic            reset = 1'b1;
  logic            ce = 1'b1;
  logic            send = 1'b0;
  logic [15:0]     word = 16'h0000;
  logic [ADDR_W-1:0] index_base = 12'h300;
  bus_req_t        bus_req = '0;
  logic [15:0]     instr_word;
  logic            instr_valid, instr_ready;
  logic [7:0]      bus_rdata, wreg_out;
  logic [4:0]      status_out;
  logic [PC_W-1:0] pc_out, exp_pc = PC_RST;
  int              err_count = 0;
  int              compares = 0;
  logic [7:0] bop [6] = '{OPC_BC, OPC_BC, OPC_BNC, OPC_BNC, OPC_BN, OPC_BN};
  logic [7:0] bst [6] = '{8'h01, 8'h1E, 8'h10, 8'h01, 8'h10, 8'h0F};
  logic [7:0] bof [6] = '{8'h05, 8'h80, 8'h7F, 8'hFE, 8'h80, 8'h7F};
  logic       bjp [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  always #5 mclk = ~mclk;

  instr_exec instr_exec_inst (
    .mclk(mclk), .reset(reset), .ce(ce), .instr_word(instr_word), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .index_base(index_base), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .pc_out(pc_out), .wreg_out(wreg_out), .status_out(status_out)
  );
  fetch_model fetch_model_inst (
    .mclk(mclk), .reset(reset), .send(send), .word(word), .instr_ready(instr_ready),
    .instr_word(instr_word), .instr_valid(instr_valid)
  );

  task automatic wrap_up();
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [PC_W-1:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus_wr(input logic [BUS_AW-1:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= {a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [BUS_AW-1:0] a, input logic [7:0] e, input string nm);
    @(posedge mclk);
    bus_req <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    check(nm, bus_rdata, e);
  endtask

  // Waits on each of the two handshake steps for at most 20 cycles, so a hang fails a check instead
  task automatic run(input logic [15:0] w, input logic jmp);
    int i;
    @(posedge mclk);
    send <= 1'b1;
    word <= w;
    @(posedge mclk);
    send <= 1'b0;
    #1;
    for (i = 0; i < 20 && instr_valid !== 1'b0; i++) @(posedge mclk) #1;
    check("word taken", instr_valid, 1'b0);
    for (i = 0; i < 20 && instr_ready !== 1'b1; i++) @(posedge mclk) #1;
    check("ready back", instr_ready, 1'b1);
    exp_pc = exp_pc + PC_STEP + (jmp ? {{12{w[7]}}, w[7:0], 1'b0} : 21'h000000);
  endtask

  initial begin
    #50000;
    err_count++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    bus_rd(REG_WREG, WREG_RST, "wreg rst");
    bus_rd(REG_STATUS, 8'h00, "status rst");
    bus_rd(13'h0004, 8'h00, "unmapped");
    check("pc rst", pc_out, PC_RST);
    bus_wr(REG_BANK, 8'h02);
    bus_wr(13'h1205, 8'h02);
    bus_wr(REG_WREG, 8'h4D);
    bus_wr(REG_STATUS, 8'h01);
    run(16'h2105, 1'b0);
    check("addc w", wreg_out, 8'h50);
    check("addc st", status_out, 5'h02);
    check("pc step", pc_out, exp_pc);
    bus_wr(13'h1FF0, 8'h80);
    bus_wr(REG_WREG, 8'h80);
    bus_wr(REG_STATUS, 8'h00);
    run(16'h22F0, 1'b0);
    check("addc keep w", wreg_out, 8'h80);
    check("addc ovf st", status_out, 5'h0D);
    bus_rd(13'h1FF0, 8'h00, "addc file");
    bus_wr(REG_WREG, 8'hA3);
    bus_wr(REG_STATUS, 8'h1F);
    run(16'h0B5F, 1'b0);
    check("andl w", wreg_out, 8'h03);
    check("andl st", status_out, 5'h0B);
    bus_wr(13'h1010, 8'hC2);
    bus_wr(REG_WREG, 8'h80);
    run(16'h1610, 1'b0);
    check("andf st", status_out, 5'h1B);
    bus_rd(13'h1010, 8'h80, "andf file");
    bus_wr(REG_CTRL, 8'h01);
    bus_wr(13'h135F, 8'h0F);
    bus_wr(13'h105F, 8'hF0);
    bus_wr(REG_WREG, 8'hFF);
    run(16'h145F, 1'b0);
    check("indexed", wreg_out, 8'h0F);
    bus_wr(13'h1F60, 8'h3C);
    bus_wr(13'h1360, 8'hC3);
    run(16'h1460, 1'b0);
    check("above window", wreg_out, 8'h0C);
    // A write while the clock enable is low must leave W untouched
    ce <= 1'b0;
    bus_wr(REG_WREG, 8'h55);
    ce <= 1'b1;
    bus_rd(REG_WREG, 8'h0C, "frozen w");
    bus_wr(REG_CTRL, 8'h00);
    bus_wr(13'h1020, 8'hC7);
    bus_wr(REG_STATUS, 8'h15);
    run(16'h9E20, 1'b0);
    bus_rd(13'h1020, 8'h47, "bit clear");
    check("bclr st", status_out, 5'h15);
    for (int k = 0; k < 6; k++) begin
      bus_wr(REG_STATUS, bst[k]);
      run({bop[k], bof[k]}, bjp[k]);
      check("branch pc", pc_out, exp_pc);
    end
    wrap_up();
  end
endmodule
